// File: src/eep_pkg.sv
// constants and state encoding for the serial eeprom slave
`default_nettype none
package eep_pkg;
    // ============================================================
    // protocol constants
    localparam logic [3:0] DEV_CODE = 4'ha;      // device type code, upper nibble
    localparam logic [3:0] BYTE_BITS = 4'h8;     // bits per serial word
    localparam int PAGE_BYTES = 16;              // page buffer depth
    localparam int ARRAY_BYTES = 256;            // array depth
    localparam int HALF_MSB = 7;                 // address bit that selects upper half
    // ============================================================
    // timing
    localparam int WR_TIME_MS = 5;               // internal_write_duration, ms
    localparam int CLK_FREQ_KHZ = 200000;        // ref clock rate
    localparam int WR_CYCLES = WR_TIME_MS * CLK_FREQ_KHZ;
    localparam int WR_CNT_W = 20;
    // ============================================================
    // synchroniser lane positions
    localparam int SYN_W = 8;
    localparam int SYN_SCL = 0;
    localparam int SYN_SDA = 1;
    localparam int SYN_STRAP = 2;                // three lanes from here
    localparam int SYN_WP = 5;
    localparam int SYN_PERM = 6;
    localparam int SYN_REV = 7;
    // ============================================================
    // link state machine
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_RX_DEV = 10'h002,
        ST_ACK_DEV = 10'h004,
        ST_RX_WORD = 10'h008,
        ST_ACK_WORD = 10'h010,
        ST_RX_DATA = 10'h020,
        ST_ACK_DATA = 10'h040,
        ST_TX_DATA = 10'h080,
        ST_HOST_ACK = 10'h100,
        ST_WRITING = 10'h200
    } eep_state_type;
endpackage
`default_nettype wire

// File: src/eep_sync.sv
// two-flop synchroniser bank for pins from outside the clock domain
`default_nettype none
module eep_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } eep_sync_regs_type;

    eep_sync_regs_type q_reg;
    eep_sync_regs_type q_next;

    // ============================================================
    // first stage feeds only the second
    always_comb begin
        q_next.meta = d_i;
        q_next.sync = q_reg.meta;
    end

    // ============================================================
    // both stages idle high, matching released bus lines
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_reg <= '1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg.sync;
endmodule
`default_nettype wire

// File: src/eep_dev.sv
// serial eeprom slave: two-wire link, page buffer, array and write protection
//
// Contract
// - incoming data bits are sampled on serial clock rising edges
// - outgoing data bits change on serial clock falling edges only
// - data line is only pulled low or released, never driven high
// - three strap inputs set the device address, eight devices share a bus
// - with protect pin low and no protection registers, whole array writable
// - protect pin high blocks all array writes, reads still work
// - protect pin low plus either protection register blocks first half only
// - self-timed write starts at stop ending a write with at least one unprotected byte, runs without clock
// - device word acknowledged only when its three bits match the straps
`default_nettype none
module eep_dev #(
    parameter int WRITE_CYCLES = eep_pkg::WR_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic ADDR_STRAP_BIT0_I,
    input wire logic ADDR_STRAP_BIT1_I,
    input wire logic ADDR_STRAP_BIT2_I,
    input wire logic WP_I,
    input wire logic PERM_PROT_SET_I,
    input wire logic REV_PROT_SET_I
);
    typedef struct packed {
        eep_pkg::eep_state_type st;
        logic scl_q;
        logic sda_q;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic [7:0] addr;
        logic [3:0] page;
        logic [eep_pkg::PAGE_BYTES-1:0][7:0] pbuf;
        logic [eep_pkg::PAGE_BYTES-1:0] pmask;
        logic oe_n;
        logic [eep_pkg::WR_CNT_W-1:0] wtimer;
    } eep_regs_type;

    eep_regs_type q_reg;
    eep_regs_type q_next;
    logic [7:0] mem [eep_pkg::ARRAY_BYTES];
    logic [eep_pkg::SYN_W-1:0] syn;
    logic scl_s;
    logic sda_s;
    logic [2:0] strap;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic commit;
    logic [7:0] rd_byte;

    // ============================================================
    // protection decode
    function automatic logic is_protected(input logic [7:0] a, input logic wp,
                                          input logic perm, input logic rev);
        is_protected = wp | ((perm | rev) & ~a[eep_pkg::HALF_MSB]);
    endfunction

    // ============================================================
    // pin synchronisers
    eep_sync #(.W(eep_pkg::SYN_W)) u_sync (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .d_i({REV_PROT_SET_I, PERM_PROT_SET_I, WP_I, ADDR_STRAP_BIT2_I,
              ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I, SDA_I, SCL_I}),
        .q_o(syn)
    );

    // ============================================================
    // edge and bus condition detection
    assign scl_s = syn[eep_pkg::SYN_SCL];
    assign sda_s = syn[eep_pkg::SYN_SDA];
    assign strap = syn[eep_pkg::SYN_STRAP +: 3];
    assign scl_rise = scl_s & ~q_reg.scl_q;
    assign scl_fall = ~scl_s & q_reg.scl_q;
    assign start_cond = scl_s & q_reg.scl_q & q_reg.sda_q & ~sda_s;
    assign stop_cond = scl_s & q_reg.scl_q & ~q_reg.sda_q & sda_s;
    assign rd_byte = mem[q_reg.addr];

    // ============================================================
    // link state machine
    always_comb begin
        q_next = q_reg;
        q_next.scl_q = scl_s;
        q_next.sda_q = sda_s;
        commit = 1'b0;
        if (q_reg.st == eep_pkg::ST_WRITING) begin
            // self-timed, ignores the link until done
            q_next.oe_n = 1'b1;
            if (q_reg.wtimer == eep_pkg::WR_CNT_W'(WRITE_CYCLES - 1)) begin
                q_next.st = eep_pkg::ST_IDLE;
            end else begin
                q_next.wtimer = eep_pkg::WR_CNT_W'(q_reg.wtimer + 1'b1);
            end
        end else if (start_cond) begin
            q_next.st = eep_pkg::ST_RX_DEV;
            q_next.cnt = 4'h0;
            q_next.oe_n = 1'b1;
        end else if (stop_cond) begin
            q_next.oe_n = 1'b1;
            q_next.st = eep_pkg::ST_IDLE;
            if ((q_reg.st == eep_pkg::ST_RX_DATA || q_reg.st == eep_pkg::ST_ACK_DATA)
                && q_reg.pmask != '0) begin
                commit = 1'b1;
                q_next.wtimer = '0;
                q_next.st = eep_pkg::ST_WRITING;
            end
        end else begin
            case (q_reg.st)
                eep_pkg::ST_RX_DEV, eep_pkg::ST_RX_WORD, eep_pkg::ST_RX_DATA: begin
                    if (scl_rise && q_reg.cnt != eep_pkg::BYTE_BITS) begin
                        q_next.sh = {q_reg.sh[6:0], sda_s};
                        q_next.cnt = 4'(q_reg.cnt + 4'h1);
                    end else if (scl_fall && q_reg.cnt == eep_pkg::BYTE_BITS) begin
                        q_next.oe_n = 1'b0;
                        if (q_reg.st == eep_pkg::ST_RX_DEV) begin
                            if (q_reg.sh[7:4] == eep_pkg::DEV_CODE
                                && q_reg.sh[3:1] == strap) begin
                                q_next.rw = q_reg.sh[0];
                                q_next.st = eep_pkg::ST_ACK_DEV;
                            end else begin
                                q_next.oe_n = 1'b1;
                                q_next.st = eep_pkg::ST_IDLE;
                            end
                        end else if (q_reg.st == eep_pkg::ST_RX_WORD) begin
                            q_next.addr = q_reg.sh;
                            q_next.page = q_reg.sh[7:4];
                            q_next.st = eep_pkg::ST_ACK_WORD;
                        end else begin
                            if (!is_protected(q_reg.addr, syn[eep_pkg::SYN_WP],
                                              syn[eep_pkg::SYN_PERM],
                                              syn[eep_pkg::SYN_REV])) begin
                                q_next.pbuf[q_reg.addr[3:0]] = q_reg.sh;
                                q_next.pmask[q_reg.addr[3:0]] = 1'b1;
                            end
                            // page roll-over keeps the upper nibble
                            q_next.addr[3:0] = 4'(q_reg.addr[3:0] + 4'h1);
                            q_next.st = eep_pkg::ST_ACK_DATA;
                        end
                    end
                end
                eep_pkg::ST_ACK_DEV: begin
                    if (scl_fall) begin
                        q_next.cnt = 4'h0;
                        if (q_reg.rw) begin
                            q_next.sh = rd_byte;
                            q_next.oe_n = rd_byte[7];
                            q_next.cnt = 4'h1;
                            q_next.addr = 8'(q_reg.addr + 8'h01);
                            q_next.st = eep_pkg::ST_TX_DATA;
                        end else begin
                            q_next.oe_n = 1'b1;
                            q_next.st = eep_pkg::ST_RX_WORD;
                        end
                    end
                end
                eep_pkg::ST_ACK_WORD, eep_pkg::ST_ACK_DATA: begin
                    if (scl_fall) begin
                        q_next.oe_n = 1'b1;
                        q_next.cnt = 4'h0;
                        if (q_reg.st == eep_pkg::ST_ACK_WORD) begin
                            q_next.pmask = '0;
                        end
                        q_next.st = eep_pkg::ST_RX_DATA;
                    end
                end
                eep_pkg::ST_TX_DATA: begin
                    if (scl_fall) begin
                        if (q_reg.cnt == eep_pkg::BYTE_BITS) begin
                            q_next.oe_n = 1'b1;
                            q_next.st = eep_pkg::ST_HOST_ACK;
                        end else begin
                            q_next.oe_n = q_reg.sh[6];
                            q_next.sh = {q_reg.sh[6:0], 1'b0};
                            q_next.cnt = 4'(q_reg.cnt + 4'h1);
                        end
                    end
                end
                eep_pkg::ST_HOST_ACK: begin
                    if (scl_rise) begin
                        // host ack reuses the load path on the next fall
                        q_next.st = sda_s ? eep_pkg::ST_IDLE : eep_pkg::ST_ACK_DEV;
                    end
                end
                eep_pkg::ST_IDLE: begin
                    q_next.oe_n = 1'b1;
                end
                default: begin
                    q_next.oe_n = 1'b1;
                    q_next.st = eep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q_reg <= '0;
            q_reg.st <= eep_pkg::ST_IDLE;
            q_reg.scl_q <= 1'b1;
            q_reg.sda_q <= 1'b1;
            q_reg.oe_n <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    // ============================================================
    // array update from the page buffer, masked lanes only
    always_ff @(posedge REF_CLK_I) begin
        for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
            if (commit && q_reg.pmask[i]) begin
                mem[{q_reg.page, 4'(i)}] <= q_reg.pbuf[i];
            end
        end
    end

    // ============================================================
    // open-drain output: level is always low, only the enable moves
    assign SDA_O = 1'b0;
    assign SDA_OE_N_O = q_reg.oe_n;
endmodule
`default_nettype wire

// File: verif/eep_dev_properties.sv
// concurrent pin checks for the serial eeprom slave
`default_nettype none
module eep_dev_properties #(
    parameter int WRITE_CYCLES = 200
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_N_O
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // bus conditions seen on the wire
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence start_seen;
        SCL_I && $past(SCL_I) && $fell(SDA_I);
    endsequence
    sequence stop_seen;
        SCL_I && $past(SCL_I) && $rose(SDA_I);
    endsequence
    // ============================================================
    // output timing and drive strength
    chk_out_low: assert property (SDA_O == 1'b0)
        else $error("data output value not low");
    chk_pull_low_phase: assert property ($fell(SDA_OE_N_O) |-> !SCL_I && !$past(SCL_I))
        else $error("data pulled outside clock low phase");
    chk_release_low_phase: assert property ($rose(SDA_OE_N_O) |-> !SCL_I)
        else $error("data released outside clock low phase");
    chk_hold_clk_high: assert property ($rose(SCL_I) |=> $stable(SDA_OE_N_O) [*3])
        else $error("data moved while clock high");
    chk_pull_bounded: assert property ($fell(SDA_OE_N_O) |-> ##[1:100] SDA_OE_N_O)
        else $error("data line held low too long");
    chk_reset_released: assert property ($rose(NRST_I) |-> SDA_OE_N_O [*3])
        else $error("data line pulled after reset");
    chk_word_after_start: assert property (start_seen |=> SDA_OE_N_O [*8])
        else $error("pull before device word received");
    chk_idle_after_stop: assert property (stop_seen |=> SDA_OE_N_O [*8])
        else $error("pull after stop condition");
    // main scenarios reached
    cov_ack: cover property ($fell(SDA_OE_N_O));
    cov_start: cover property (start_seen);
    cov_stop: cover property (stop_seen);
endmodule
bind eep_dev eep_dev_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O)
);
`default_nettype wire

// File: verif/eep_ctl_model.sv
// two-wire bus controller: drives the serial clock, pulls or releases data
`default_nettype none
module eep_ctl_model (
    output var logic scl_o,
    output var logic sda_rel_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // idle bus: both lines released to the pull-up, clock stands still
    initial begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    // start: data falls while clock high
    task automatic start();
        #10 sda_rel_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_rel_o = 1'b0;
        #20 scl_o = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        #10 sda_rel_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_rel_o = 1'b1;
        #20;
    endtask
    // nine 48 ns clock pulses, msb first, wire read mid high phase
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #8 sda_rel_o = tx[i];
            #20 scl_o = 1'b1;
            #10 rx[i] = sda_i;
            #10 scl_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: verif/test_serial_eeprom_pin_write_protect.sv
// self-checking bench: random page writes and reads under every protection mode
`default_nettype none
module test_serial_eeprom_pin_write_protect;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WCYC = 200;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] strap = 3'h0;
    logic wp = 1'b0, perm = 1'b0, rev = 1'b0;
    logic scl, rel, oe_n, dout;
    wire sda = (oe_n | dout) & rel;  // pulled-up wire, low while either party pulls
    logic [7:0] mem [256];
    bit known [256];
    logic [31:0] seed = 32'hcd3d;
    int n_fail = 0;
    int num_checks = 0;
    `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); end end
    always #2.5 clk = ~clk;
    eep_dev #(.WRITE_CYCLES(WCYC)) dut (
        .REF_CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda), .SDA_O(dout),
        .SDA_OE_N_O(oe_n), .ADDR_STRAP_BIT0_I(strap[0]), .ADDR_STRAP_BIT1_I(strap[1]),
        .ADDR_STRAP_BIT2_I(strap[2]), .WP_I(wp), .PERM_PROT_SET_I(perm), .REV_PROT_SET_I(rev)
    );
    eep_ctl_model ctl (.scl_o(scl), .sda_rel_o(rel), .sda_i(sda));
    // ============================================================
    // expectation helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic guarded(input logic [7:0] a);
        return wp | ((perm | rev) & ~a[eep_pkg::HALF_MSB]);
    endfunction
    // device word with straps in bits 3:1, ack returned high when pulled
    task automatic devword(input logic rw, input logic [2:0] s, output logic ack);
        logic [8:0] rx;
        ctl.xfer({eep_pkg::DEV_CODE, s, rw, 1'b1}, rx);
        ack = ~rx[0];
    endtask
    // page write with rollover, then probe the busy window
    task automatic page_write(input logic [7:0] a, input int n);
        logic ack;
        logic kept;
        logic [8:0] rx;
        kept = 1'b0;
        ctl.start();
        devword(1'b0, strap, ack);
        `CHK("dev ack", 1'b1, ack)
        ctl.xfer({a, 1'b1}, rx);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            ctl.xfer({seed[7:0], 1'b1}, rx);
            `CHK("data ack", 1'b0, rx[0])
            if (!guarded(a)) begin
                mem[a] = seed[7:0];
                known[a] = 1'b1;
                kept = 1'b1;
            end
            a[3:0] = a[3:0] + 4'h1;
        end
        ctl.stop();
        ctl.start();
        devword(1'b0, strap, ack);
        `CHK("busy ack", ~kept, ack)
        ctl.stop();
        repeat (WCYC + 20) @(posedge clk);
    endtask
    // random read: set address, repeated start, n bytes, nack on last
    task automatic rand_read(input logic [7:0] a, input int n);
        logic ack;
        logic [8:0] rx;
        ctl.start();
        devword(1'b0, strap, ack);
        ctl.xfer({a, 1'b1}, rx);
        ctl.start();
        devword(1'b1, strap, ack);
        `CHK("read ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            ctl.xfer({8'hff, i == n - 1}, rx);
            if (known[a]) `CHK("read data", mem[a], rx[8:1])
            a = a + 8'h1;
        end
        ctl.stop();
    endtask
    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ============================================================
    // main sequence: every protection mode, then random ones
    initial begin
        logic ack;
        logic [7:0] a;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // prefill one page in each half so every later read is checked
        repeat (4) @(posedge clk);
        page_write(8'h30, 16);
        page_write(8'hb0, 16);
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            seed = xs(seed);
            strap <= seed[2:0];
            {wp, perm, rev} <= (k < 8) ? k[2:0] : seed[5:3];
            a = {seed[15], 3'h3, seed[11:8] | {4{k[0]}}};
            repeat (4) @(posedge clk);
            ctl.start();
            devword(1'b0, seed[2:0] ^ {seed[18:17], 1'b1}, ack);
            `CHK("foreign nack", 1'b0, ack)
            ctl.stop();
            page_write(a, 1 + seed[20:19]);
            rand_read(a & 8'hf0, 16);
            rand_read((a ^ 8'h80) & 8'hfe, 2);
        end
        close_out();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
